//--- hdl/ctpu_pkg.sv
// Purpose: constants for the cascadable timer and pwm unit
// Assumes: AHB-Lite word registers, byte address is four times the index
// Notes: control bit positions and interrupt register indexes are local
// What this block does
// RULE1 - cascaded pair interrupts once, even timer
// RULE2 - even timer holds low byte
// RULE3 - reload count when posting interrupt
// RULE4 - cascaded timers always reload, free-run
// RULE5 - repeated timeout before service not flagged
// RULE6 - control write starts from current count
// RULE7 - internal clock, decrement every eighth cycle
// RULE8 - independent timers reload only if selected
// RULE9 - pwm values from low and high pairs
// RULE10 - pwm alternates low then high reload
// RULE11 - low end even irq, high end odd
// RULE12 - pwm starts in high phase
// RULE13 - software preloads counts with high value
// RULE14 - software sets direction and special function
// RULE15 - timer a timeout toggles port line
// RULE16 - all timers disabled after reset
// RULE17 - control holds enables, cascade, reload, pwm
// RULE18 - decrement by one, timeout at zero
package ctpu_pkg;
	// register indexes; byte address is index times four
	localparam logic [7:0] IDX_CTRL     = 8'hC0;
	localparam logic [7:0] IDX_RLO_A    = 8'hC4;
	localparam logic [7:0] IDX_RLO_B    = 8'hC5;
	localparam logic [7:0] IDX_RHI_A    = 8'hC6;
	localparam logic [7:0] IDX_RHI_B    = 8'hC7;
	localparam logic [7:0] IDX_RLD_C    = 8'hC8;
	localparam logic [7:0] IDX_RLD_D    = 8'hC9;
	localparam logic [7:0] IDX_CNT_C    = 8'hCA;
	localparam logic [7:0] IDX_CNT_D    = 8'hCB;
	localparam logic [7:0] IDX_CNT_A    = 8'hCC;
	localparam logic [7:0] IDX_CNT_B    = 8'hCD;
	localparam logic [7:0] IDX_PB_DIR   = 8'hD6;
	localparam logic [7:0] IDX_PB_SFR   = 8'hD7;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hE0;
	localparam logic [7:0] IDX_IRQ_CLR  = 8'hE1;
	localparam logic [7:0] IDX_IRQ_EN   = 8'hE2;
	// control fields
	localparam int CTRL_EN_LSB   = 0;
	localparam int CTRL_CASC_LSB = 4;
	localparam int CTRL_RLD_LSB  = 8;
	localparam int CTRL_PWM_BIT  = 12;
	localparam int CTRL_W        = 13;
	localparam logic [12:0] CTRL_RST = 13'h0000;
	// port b line one fields
	localparam int PB_LINE_BIT = 1;
	localparam int SFR_TOGGLE_OUTPUT_MODE_BIT = 1;
	localparam logic [7:0] PORT_RST = 8'h00;
	// prescaler
	localparam int TICK_DIV = 8;
	localparam logic [31:0] RESP_OKAY = 32'h00000000;
endpackage : ctpu_pkg

//--- hdl/ctpu_tick_if.sv
// Purpose: carries the prescaled count tick between modules
// Assumes: single clock domain
// Notes: tick is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface ctpu_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface : ctpu_tick_if
`default_nettype wire

//--- hdl/ctpu_prescale.sv
// Purpose: divides hclk into a count tick
// Assumes: hclk is the oscillator clock
// Notes: runs free; timers gate on their own enables
`timescale 1ns/10ps
`default_nettype none
module ctpu_prescale #(
	parameter int DIV = ctpu_pkg::TICK_DIV
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// tick out
	ctpu_tick_if.src  tk
);
	localparam int W = $clog2(DIV);
	logic [W-1:0] div_ff;
	logic         tick_ff;

	initial begin
		if (DIV < 2) $error("ctpu_prescale: DIV must be at least 2");
	end

	// one tick every DIV cycles  [RULE7]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (div_ff == W'(DIV - 1));
			div_ff  <= (div_ff == W'(DIV - 1)) ? '0 : div_ff + W'(1);
		end
	end

	assign tk.tick = tick_ff;
endmodule : ctpu_prescale
`default_nettype wire

//--- hdl/ctpu_top.sv
// Purpose: four 8-bit timers, cascadable pairs, pwm pair, toggle output
// Assumes: AHB-Lite slave, single transfers of whole words
// Notes: reads take one wait state, writes take none
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ctpu_top (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [9:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// timer output on port b line one
	output logic             port_b_line_one_o,
	output logic             port_b_line_one_oe,
	// interrupt
	output logic             irq
);
	// prescaled tick shared with the divider
	ctpu_tick_if tk ();

	// count and reload storage; index 0..3 is timer a..d
	logic [7:0]  cnt_ff [4];
	logic [7:0]  rlo_ff [4];
	// high-phase reload bytes exist for the first pair only
	logic [7:0]  rhi_ff [2];
	logic [7:0]  nxt_cnt [4];

	// software-visible control and port b line one setup
	logic [12:0] ctrl_ff;
	logic [7:0]  dir_ff;
	logic [7:0]  sfr_ff;

	// events, sticky status and interrupt enables
	logic [3:0]  stat_ff;
	logic [3:0]  ien_ff;
	logic [3:0]  ev;

	// pwm phase and toggle output state
	logic        phase_hi_ff;
	logic        nxt_phase_hi;
	logic        tog_ff;
	logic        oe_ff;
	logic        irq_ff;

	// bus pipeline: address phase held over into the data phase
	logic        wr_pend_ff;
	logic        rd_pend_ff;
	logic [7:0]  idx_ff;
	logic [31:0] hrdata_ff;
	logic        hreadyout_ff;
	logic        addr_ok;
	logic        wr_go;
	logic [3:0]  clr_mask;

	ctpu_prescale #(
		.DIV (ctpu_pkg::TICK_DIV)
	) u_pre (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tk      (tk)
	);

	// 16-bit decrement of a count pair
	function automatic logic [15:0] dec16(input logic [15:0] v);
		dec16 = v - 16'h0001;
	endfunction : dec16

	// 8-bit decrement
	function automatic logic [7:0] dec8(input logic [7:0] v);
		dec8 = v - 8'h01;
	endfunction : dec8

	// register read mux
	function automatic logic [31:0] rd_mux(input logic [7:0] i);
		rd_mux = 32'h00000000;
		case (i)
			ctpu_pkg::IDX_CTRL:     rd_mux = {19'h00000, ctrl_ff};
			ctpu_pkg::IDX_RLO_A:    rd_mux = {24'h000000, rlo_ff[0]};
			ctpu_pkg::IDX_RLO_B:    rd_mux = {24'h000000, rlo_ff[1]};
			ctpu_pkg::IDX_RHI_A:    rd_mux = {24'h000000, rhi_ff[0]};
			ctpu_pkg::IDX_RHI_B:    rd_mux = {24'h000000, rhi_ff[1]};
			ctpu_pkg::IDX_RLD_C:    rd_mux = {24'h000000, rlo_ff[2]};
			ctpu_pkg::IDX_RLD_D:    rd_mux = {24'h000000, rlo_ff[3]};
			ctpu_pkg::IDX_CNT_A:    rd_mux = {24'h000000, cnt_ff[0]};
			ctpu_pkg::IDX_CNT_B:    rd_mux = {24'h000000, cnt_ff[1]};
			ctpu_pkg::IDX_CNT_C:    rd_mux = {24'h000000, cnt_ff[2]};
			ctpu_pkg::IDX_CNT_D:    rd_mux = {24'h000000, cnt_ff[3]};
			ctpu_pkg::IDX_PB_DIR:   rd_mux = {24'h000000, dir_ff};
			ctpu_pkg::IDX_PB_SFR:   rd_mux = {24'h000000, sfr_ff};
			ctpu_pkg::IDX_IRQ_STAT: rd_mux = {28'h0000000, stat_ff};
			ctpu_pkg::IDX_IRQ_EN:   rd_mux = {28'h0000000, ien_ff};
			default:                rd_mux = 32'h00000000;
		endcase
	endfunction : rd_mux

	// address phase accepted; size and burst type are not checked
	assign addr_ok = hsel & htrans[1] & hready;
	assign wr_go   = wr_pend_ff;
	assign clr_mask = (wr_go && idx_ff == ctpu_pkg::IDX_IRQ_CLR) ? hwdata[3:0] : 4'h0;

	// address phase capture
	// the index is kept so the write can land at the end of the data phase,
	// when hwdata is finally valid; a write therefore never stalls the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			idx_ff     <= 8'h00;
		end else begin
			wr_pend_ff <= addr_ok & hwrite;
			rd_pend_ff <= addr_ok & ~hwrite;
			if (addr_ok) begin
				idx_ff <= haddr[9:2];
			end
		end
	end

	// read data a cycle late so a write just before is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff    <= 32'h00000000;
			hreadyout_ff <= 1'b1;
		end else begin
			hreadyout_ff <= ~(addr_ok & ~hwrite);
			if (rd_pend_ff) begin
				hrdata_ff <= rd_mux(idx_ff);
			end
		end
	end

	// timer datapath: decrement on tick, detect zero, reload
	// a cascaded pair is driven by the even timer's enable; the odd enable
	// is ignored so software cannot start half of a 16-bit count.
	// pwm only applies to the first pair and only while it is cascaded.
	// zero is detected on the decremented value, so a count loaded with one
	// times out on the very next tick.
	always_comb begin
		logic [15:0] v16;
		logic [7:0]  v8;
		v16 = 16'h0000;
		v8  = 8'h00;
		for (int k = 0; k < 4; k++) begin
			nxt_cnt[k] = cnt_ff[k];
		end
		ev           = 4'h0;
		nxt_phase_hi = phase_hi_ff;
		if (tk.tick) begin
			for (int p = 0; p < 2; p++) begin
				if (ctrl_ff[ctpu_pkg::CTRL_CASC_LSB + p]) begin
					if (ctrl_ff[ctpu_pkg::CTRL_EN_LSB + 2 * p]) begin
						// odd timer is the high byte  [RULE2]
						v16 = dec16({cnt_ff[2 * p + 1], cnt_ff[2 * p]}); // [RULE18]
						if (v16 == 16'h0000) begin
							if (p == 0 && ctrl_ff[ctpu_pkg::CTRL_PWM_BIT]) begin
								if (phase_hi_ff) begin
									// high phase ends: odd irq, low values  [RULE11] [RULE10]
									ev[1]        = 1'b1;
									nxt_cnt[0]   = rlo_ff[0]; // [RULE9]
									nxt_cnt[1]   = rlo_ff[1];
									nxt_phase_hi = 1'b0;
								end else begin
									ev[0]        = 1'b1; // [RULE11]
									nxt_cnt[0]   = rhi_ff[0]; // [RULE9]
									nxt_cnt[1]   = rhi_ff[1];
									nxt_phase_hi = 1'b1;
								end
							end else begin
								// single even irq, forced reload  [RULE1] [RULE4] [RULE3]
								ev[2 * p]          = 1'b1;
								nxt_cnt[2 * p]     = rlo_ff[2 * p];
								nxt_cnt[2 * p + 1] = rlo_ff[2 * p + 1];
							end
						end else begin
							nxt_cnt[2 * p]     = v16[7:0];
							nxt_cnt[2 * p + 1] = v16[15:8];
						end
					end
				end else begin
					for (int q = 0; q < 2; q++) begin
						if (ctrl_ff[ctpu_pkg::CTRL_EN_LSB + 2 * p + q]) begin
							v8 = dec8(cnt_ff[2 * p + q]); // [RULE18]
							ev[2 * p + q] = (v8 == 8'h00); // [RULE8]
							// reload only when selected, else count on from zero, wrapping to FF  [RULE8] [RULE3]
							if (v8 == 8'h00 && ctrl_ff[ctpu_pkg::CTRL_RLD_LSB + 2 * p + q]) begin
								nxt_cnt[2 * p + q] = rlo_ff[2 * p + q];
							end else begin
								nxt_cnt[2 * p + q] = v8;
							end
						end
					end
				end
			end
		end
	end

	// count registers; a software write overrides the tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int k = 0; k < 4; k++) begin
				cnt_ff[k] <= 8'h00;
			end
		end else begin
			for (int k = 0; k < 4; k++) begin
				cnt_ff[k] <= nxt_cnt[k];
			end
			if (wr_go) begin
				case (idx_ff)
					ctpu_pkg::IDX_CNT_A: cnt_ff[0] <= hwdata[7:0];
					ctpu_pkg::IDX_CNT_B: cnt_ff[1] <= hwdata[7:0];
					ctpu_pkg::IDX_CNT_C: cnt_ff[2] <= hwdata[7:0];
					ctpu_pkg::IDX_CNT_D: cnt_ff[3] <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// reload registers and port b control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int k = 0; k < 4; k++) begin
				rlo_ff[k] <= 8'h00;
			end
			rhi_ff[0] <= 8'h00;
			rhi_ff[1] <= 8'h00;
			dir_ff    <= ctpu_pkg::PORT_RST;
			sfr_ff    <= ctpu_pkg::PORT_RST;
		end else if (wr_go) begin
			case (idx_ff)
				ctpu_pkg::IDX_RLO_A:  rlo_ff[0] <= hwdata[7:0];
				ctpu_pkg::IDX_RLO_B:  rlo_ff[1] <= hwdata[7:0];
				ctpu_pkg::IDX_RLD_C:  rlo_ff[2] <= hwdata[7:0];
				ctpu_pkg::IDX_RLD_D:  rlo_ff[3] <= hwdata[7:0];
				ctpu_pkg::IDX_RHI_A:  rhi_ff[0] <= hwdata[7:0];
				ctpu_pkg::IDX_RHI_B:  rhi_ff[1] <= hwdata[7:0];
				ctpu_pkg::IDX_PB_DIR: dir_ff    <= hwdata[7:0];
				ctpu_pkg::IDX_PB_SFR: sfr_ff    <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// control: writing it never reloads, counting resumes from count  [RULE6] [RULE17]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= ctpu_pkg::CTRL_RST; // [RULE16]
		end else if (wr_go && idx_ff == ctpu_pkg::IDX_CTRL) begin
			ctrl_ff <= hwdata[12:0];
		end
	end

	// pwm phase restarts high on any control write or when pwm is off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_hi_ff <= 1'b1;
		end else if ((wr_go && idx_ff == ctpu_pkg::IDX_CTRL) || !ctrl_ff[ctpu_pkg::CTRL_PWM_BIT]) begin
			phase_hi_ff <= 1'b1; // [RULE12]
		end else begin
			phase_hi_ff <= nxt_phase_hi;
		end
	end

	// sticky status; set wins over clear, a second timeout just stays set  [RULE5]
	// letting the set win means a timeout that lands on the clear write is
	// never lost; the cost is that software may see the bit survive a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= 4'h0;
		end else begin
			stat_ff <= (stat_ff & ~clr_mask) | ev;
		end
	end

	// interrupt enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ien_ff <= 4'h0;
		end else if (wr_go && idx_ff == ctpu_pkg::IDX_IRQ_EN) begin
			ien_ff <= hwdata[3:0];
		end
	end

	// level interrupt, one cycle behind status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(stat_ff & ien_ff);
		end
	end

	// toggle on every timer a end-of-count; pwm low-end counts too  [RULE15]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tog_ff <= 1'b0;
		end else if (ev[0]) begin
			tog_ff <= ~tog_ff;
		end
	end

	// drive line only with direction and special function set  [RULE14]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= dir_ff[ctpu_pkg::PB_LINE_BIT] & sfr_ff[ctpu_pkg::SFR_TOGGLE_OUTPUT_MODE_BIT];
		end
	end

	// every output but hresp comes from a register; the response is always okay
	assign hrdata             = hrdata_ff;
	assign hreadyout          = hreadyout_ff;
	assign hresp              = ctpu_pkg::RESP_OKAY[0];
	assign port_b_line_one_o  = tog_ff;
	assign port_b_line_one_oe = oe_ff;
	assign irq                = irq_ff;
endmodule : ctpu_top
`default_nettype wire

//--- test/ctpu_top_properties.sv
// Purpose: port-level checks for ctpu_top
// Assumes: hready is tied to hreadyout
// Notes: helper regs shadow a few register writes
`timescale 1ns/10ps
`default_nettype none
module ctpu_top_properties (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [9:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// outputs
	input wire logic        port_b_line_one_o,
	input wire logic        port_b_line_one_oe,
	input wire logic        irq
);
	logic       wp_ff;
	logic [7:0] wi_ff;
	logic       enz_ff;
	logic       dir_ff;
	logic       sfr_ff;
	wire        tk = hsel & htrans[1] & hready;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// shadow of the writes the outputs depend on; data lands at end of data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_ff  <= 1'b0;
			wi_ff  <= 8'h00;
			enz_ff <= 1'b1;
			dir_ff <= 1'b0;
			sfr_ff <= 1'b0;
		end else begin
			wp_ff <= tk & hwrite;
			wi_ff <= haddr[9:2];
			if (wp_ff && wi_ff == ctpu_pkg::IDX_IRQ_EN) enz_ff <= (hwdata[3:0] == 4'h0);
			if (wp_ff && wi_ff == ctpu_pkg::IDX_PB_DIR) dir_ff <= hwdata[1];
			if (wp_ff && wi_ff == ctpu_pkg::IDX_PB_SFR) sfr_ff <= hwdata[1];
		end
	end
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (tk && hwrite |=> hreadyout)
		else $error("write stalled");
	a_wait_single: assert property (!hreadyout |=> hreadyout)
		else $error("wait state too long");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(!hreadyout))
		else $error("read data changed outside read");
	a_toggle_gap: assert property ($changed(port_b_line_one_o) |=> $stable(port_b_line_one_o)[*7])
		else $error("toggle faster than tick");
	a_irq_masked: assert property (enz_ff [*2] |-> !irq)
		else $error("irq with all enables clear");
	a_oe_follow: assert property (port_b_line_one_oe == $past(dir_ff & sfr_ff))
		else $error("output enable mismatch");
	c_read: cover property (tk && !hwrite);
	c_toggle: cover property ($rose(port_b_line_one_o));
	c_irq: cover property ($rose(irq));
endmodule : ctpu_top_properties
`default_nettype wire
bind ctpu_top ctpu_top_properties u_prop (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .port_b_line_one_o(port_b_line_one_o),
	.port_b_line_one_oe(port_b_line_one_oe), .irq(irq));

//--- test/cascadable_timer_pwm_unit_bench.sv
// Purpose: self-checking bench for ctpu_top
// Assumes: tick every 8 hclk, reads one wait state
// Notes: polls status over the bus, no random stimulus
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module cascadable_timer_pwm_unit_bench;
	logic        hclk, hresetn, hsel, hwrite;
	logic [9:0]  haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, s;
	logic        hreadyout, hresp, pb_o, pb_oe, irq;
	int          fail_count, n_tests, cyc, c0, c;
	ctpu_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .port_b_line_one_o(pb_o),
		.port_b_line_one_oe(pb_oe), .irq(irq));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// free cycle count for elapsed-time checks
	always @(posedge hclk) cyc++;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic to_fail;
		fail_count++;
		print_verdict();
	endtask : to_fail
	// one phase: wait for hready high at a rising edge, bounded
	task automatic step;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) to_fail();
			@(posedge hclk);
		end
	endtask : step
	task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {i, 2'h0};
		step();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		step();
		r = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, i, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] i, output logic [31:0] r);
		xfer(1'b0, i, 32'h0, r);
	endtask : rd
	task automatic wst;
		int n;
		n = 0;
		s = 32'h0;
		while (s === 32'h0) begin
			rd(ctpu_pkg::IDX_IRQ_STAT, s);
			n++;
			if (n > 1000) to_fail();
		end
	endtask : wst
	task automatic wtog;
		logic lv;
		lv = pb_o;
		c = 0;
		while (pb_o === lv) begin
			@(posedge hclk);
			c++;
			if (c > 500) to_fail();
		end
	endtask : wtog
	task automatic t_reset;
		rd(ctpu_pkg::IDX_CTRL, s);
		`CHK("ctrl", 32'h0, s)
		rd(ctpu_pkg::IDX_PB_SFR, s);
		`CHK("sfr", 32'h0, s)
		rd(8'h10, s);
		`CHK("unmapped", 32'h0, s)
		`CHK("irq", 1'b0, irq)
	endtask : t_reset
	task automatic t_indep;
		wr(ctpu_pkg::IDX_RLO_A, 32'h3);
		wr(ctpu_pkg::IDX_CNT_A, 32'h2);
		wr(ctpu_pkg::IDX_CTRL, 32'h101);
		wtog();
		wtog();
		`CHK("period", 24, c)
		rd(ctpu_pkg::IDX_CNT_A, s);
		`CHK("reload", 32'h3, s)
		rd(ctpu_pkg::IDX_IRQ_STAT, s);
		`CHK("stat a", 32'h1, s)
		`CHK("masked", 1'b0, irq)
		wr(ctpu_pkg::IDX_IRQ_EN, 32'hF);
		repeat (2) @(posedge hclk);
		`CHK("irq on", 1'b1, irq)
		wr(ctpu_pkg::IDX_CTRL, 32'h0);
		wr(ctpu_pkg::IDX_IRQ_CLR, 32'hF);
		rd(ctpu_pkg::IDX_IRQ_STAT, s);
		`CHK("cleared", 32'h0, s)
		wr(ctpu_pkg::IDX_CNT_A, 32'h5);
		wr(ctpu_pkg::IDX_CTRL, 32'h1);
		rd(ctpu_pkg::IDX_CNT_A, s);
		`CHK("start cnt", 1'b1, s === 32'h5 || s === 32'h4)
		wr(ctpu_pkg::IDX_CTRL, 32'h0);
	endtask : t_indep
	task automatic t_casc;
		wr(ctpu_pkg::IDX_IRQ_CLR, 32'hF);
		wr(ctpu_pkg::IDX_RLO_A, 32'h4);
		wr(ctpu_pkg::IDX_RLO_B, 32'h0);
		wr(ctpu_pkg::IDX_CNT_A, 32'h2);
		wr(ctpu_pkg::IDX_CNT_B, 32'h1);
		wr(ctpu_pkg::IDX_CTRL, 32'h11);
		c0 = cyc;
		wst();
		`CHK("casc stat", 32'h1, s)
		`CHK("casc long", 1'b1, (cyc - c0) > 2000)
		`CHK("casc short", 1'b1, (cyc - c0) < 2100)
		wr(ctpu_pkg::IDX_IRQ_CLR, 32'hF);
		c0 = cyc;
		wst();
		`CHK("rerun stat", 32'h1, s)
		`CHK("rerun short", 1'b1, (cyc - c0) < 60)
		wr(ctpu_pkg::IDX_CTRL, 32'h0);
	endtask : t_casc
	task automatic t_pwm;
		wr(ctpu_pkg::IDX_IRQ_CLR, 32'hF);
		wr(ctpu_pkg::IDX_RLO_A, 32'h2);
		wr(ctpu_pkg::IDX_RHI_A, 32'h3);
		wr(ctpu_pkg::IDX_RHI_B, 32'h0);
		wr(ctpu_pkg::IDX_CNT_A, 32'h3);
		wr(ctpu_pkg::IDX_CNT_B, 32'h0);
		wr(ctpu_pkg::IDX_PB_DIR, 32'h2);
		wr(ctpu_pkg::IDX_PB_SFR, 32'h2);
		// output enable is registered one cycle behind the port setup
		repeat (2) @(posedge hclk);
		`CHK("oe", 1'b1, pb_oe)
		wr(ctpu_pkg::IDX_CTRL, 32'h1011);
		wst();
		`CHK("pwm first", 32'h2, s)
		wr(ctpu_pkg::IDX_IRQ_CLR, 32'h2);
		wst();
		`CHK("pwm low end", 32'h1, s)
		wr(ctpu_pkg::IDX_IRQ_CLR, 32'h1);
		wst();
		`CHK("pwm high end", 32'h2, s)
	endtask : t_pwm
	initial begin
		{hsel, hwrite, haddr, htrans, hwdata, fail_count, n_tests, cyc} = '0;
		hresetn = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_indep();
		t_casc();
		t_pwm();
		print_verdict();
	end
endmodule : cascadable_timer_pwm_unit_bench
`default_nettype wire
